// ==== access_span.sv ====
// last byte address touched by a pipeline access
`timescale 1ns/1ps
module access_span (
    // access
    input wire logic [31:0] i_addr,
    input wire logic [1:0] i_size,
    // span
    output logic [31:0] o_hi
);
    logic [32:0] sum;

    // size is log2 of bytes; top saturates instead of wrapping
    always_comb begin
        sum = {1'b0, i_addr} + ((33'h1 << i_size) - 33'h1);
        o_hi = sum[32] ? 32'hffffffff : sum[31:0];
    end
endmodule

// ==== bp_unit_chk.sv ====
// port assertions for the breakpoint trigger unit
`timescale 1ns/1ps
module bp_unit_chk #(
    parameter int NUM = 2,
    parameter int SEL_W = 1
) (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // hart and csr
    input wire logic i_debug_mode,
    input wire logic i_csr_req,
    input wire logic [11:0] i_csr_addr,
    input wire logic o_csr_ack,
    input wire logic o_csr_illegal,
    input wire logic [31:0] o_csr_rdata,
    // pipeline and traps
    input wire logic i_acc_valid,
    input wire logic [31:0] i_acc_addr,
    input wire logic o_chk_valid,
    input wire logic o_bp_hit,
    input wire logic o_bp_squash,
    input wire logic [NUM-1:0] o_hit_slot,
    input wire logic o_debug_entry,
    input wire logic o_exc_take,
    input wire logic o_cause_we,
    input wire logic [31:0] o_cause,
    input wire logic o_fault_we,
    input wire logic [31:0] o_fault_addr
);
    logic map;
    assign map = i_csr_addr[11:2] == 10'h1e8;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    chk_ack_mapped: assert property (i_ce && i_csr_req && map
        |=> o_csr_ack)
        else $error("no ack for mapped csr");
    chk_ack_unmapped: assert property (i_ce && i_csr_req && !map
        |=> !o_csr_ack)
        else $error("ack for unmapped csr");
    chk_debug_legal: assert property (i_ce && i_csr_req
        && i_debug_mode |=> !o_csr_illegal)
        else $error("debug access refused");
    chk_illegal_zero: assert property (o_csr_illegal
        |-> o_csr_ack && o_csr_rdata == 32'h0)
        else $error("illegal access leaks data");
    chk_check_delay: assert property (i_ce
        |=> o_chk_valid == $past(i_acc_valid))
        else $error("check valid not one cycle late");
    chk_debug_quiet: assert property (i_ce && i_debug_mode
        |=> !o_bp_hit)
        else $error("trigger fired in debug mode");
    chk_squash_slot: assert property (o_bp_squash == o_bp_hit
        && o_bp_hit == (o_hit_slot != '0))
        else $error("squash or slot disagrees with hit");
    chk_one_action: assert property (o_bp_hit
        |-> o_chk_valid && (o_debug_entry ^ o_exc_take))
        else $error("hit without single action");
    chk_debug_mregs: assert property (o_debug_entry
        |-> !o_cause_we && !o_fault_we)
        else $error("debug entry wrote machine regs");
    chk_exc_regs: assert property (o_exc_take
        |-> o_cause_we && o_fault_we
            && o_cause == breakpoint_pkg::CAUSE_BREAKPOINT)
        else $error("exception without cause write");
    chk_fault_addr: assert property ($past(i_ce) && o_fault_we
        |-> o_fault_addr == $past(i_acc_addr))
        else $error("fault address wrong");
    chk_fault_hold: assert property (!o_fault_we && $past(i_rst_n)
        |-> $stable(o_fault_addr))
        else $error("fault address moved");
endmodule

bind hw_breakpoint_trigger_unit bp_unit_chk #(.NUM(NUM), .SEL_W(SEL_W)) i_chk (.*);

// ==== breakpoint_pkg.sv ====
// constants shared by the breakpoint trigger unit and its helpers
package breakpoint_pkg;
    // -----------------------------------------------------------------
    // sizes
    // -----------------------------------------------------------------
    localparam int NUM_SLOTS = 2;
    localparam int SEL_WIDTH = 1;
    localparam int XLEN = 32;
    localparam int MASK_LOG2_MAX = 4;

    // -----------------------------------------------------------------
    // csr addresses
    // -----------------------------------------------------------------
    localparam logic [11:0] CSR_TRIGGER_SELECT = 12'h7a0;
    localparam logic [11:0] CSR_TRIGGER_DATA_FIRST = 12'h7a1;
    localparam logic [11:0] CSR_TRIGGER_DATA_SECOND = 12'h7a2;
    localparam logic [11:0] CSR_TRIGGER_DATA_THIRD = 12'h7a3;

    // -----------------------------------------------------------------
    // match control field positions
    // -----------------------------------------------------------------
    localparam int BIT_LOAD = 0;
    localparam int BIT_STORE = 1;
    localparam int BIT_FETCH = 2;
    localparam int BIT_PRIV_U = 3;
    localparam int BIT_PRIV_M = 6;
    localparam int MATCH_LO = 7;
    localparam int MATCH_HI = 10;
    localparam int BIT_CHAIN = 11;
    localparam int ACTION_LO = 12;
    localparam int ACTION_HI = 17;
    localparam int BIT_OWNER = 27;

    // -----------------------------------------------------------------
    // field values and reset values
    // -----------------------------------------------------------------
    localparam logic [3:0] TYPE_NONE = 4'h0;
    localparam logic [3:0] TYPE_ADDR_MATCH = 4'h2;
    localparam logic [5:0] MASKMAX_VALUE = 6'h04;
    localparam logic [3:0] MATCH_EXACT = 4'h0;
    localparam logic [3:0] MATCH_NAPOT = 4'h1;
    localparam logic [3:0] MATCH_GE = 4'h2;
    localparam logic [3:0] MATCH_LT = 4'h3;
    localparam logic [5:0] ACTION_EXCEPTION = 6'h00;
    localparam logic [5:0] ACTION_DEBUG = 6'h01;
    localparam logic [31:0] CAUSE_BREAKPOINT = 32'h00000003;
    localparam logic [2:0] RST_KIND_EN = 3'h0;
    localparam logic [3:0] RST_PRIV_EN = 4'h0;
    localparam logic [3:0] RST_MATCH = 4'h0;
    localparam logic [31:0] RST_ADDRESS = 32'h00000000;
endpackage

// ==== hw_breakpoint_trigger_unit.sv ====
// hardware breakpoint unit: trigger slots, csr access and trap requests
//
// Behaviour
// R1 - two trigger slots, each usable by debug mode or machine mode
// R2 - select picks slot; first data control, second address, third reserved
// R3 - control bits 31:28 read 2, address-match trigger type
// R4 - action bits 17:12 reset 0; 0 raises exception, 1 enters debug
// R5 - load, store and fetch enables restrict matches, any combination
// R6 - user to machine privilege bits restrict matches, any combination
// R7 - match kind selects exact, power-of-two range or chained range
// R8 - range size taken from trailing ones of the address, masked bits ignored
// R9 - bits 26:21 read 4, largest range sixteen bytes
// R10 - chained pair: low slot bottom, high slot one past top, chain bit
// R11 - chained low slot compares >=, high slot <, both must hold
// R12 - timing and address-or-data select bits read zero
// R13 - debug-owned slot shows type zero to machine mode
// R14 - address register is full width read write
// R15 - breakpoint traps precise, trapping and younger instructions squashed
// R16 - any touched byte inside the range triggers
// R17 - debug action enters debug, machine registers untouched
// R18 - exception action writes breakpoint cause and faulting address
// R19 - machine access to debug-owned slot data is illegal instruction
// R20 - select keeps only implemented slot indices
`timescale 1ns/1ps
module hw_breakpoint_trigger_unit #(
    parameter int NUM = breakpoint_pkg::NUM_SLOTS,
    parameter int SEL_W = breakpoint_pkg::SEL_WIDTH
) (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // hart state
    input wire logic i_debug_mode,
    input wire logic [1:0] i_priv,
    // csr access
    input wire logic i_csr_req,
    input wire logic i_csr_we,
    input wire logic [11:0] i_csr_addr,
    input wire logic [31:0] i_csr_wdata,
    output logic o_csr_ack,
    output logic o_csr_illegal,
    output logic [31:0] o_csr_rdata,
    // pipeline access
    input wire logic i_acc_valid,
    input wire logic i_acc_load,
    input wire logic i_acc_store,
    input wire logic i_acc_fetch,
    input wire logic [31:0] i_acc_addr,
    input wire logic [1:0] i_acc_size,
    // trap requests
    output logic o_chk_valid,
    output logic o_bp_hit,
    output logic o_bp_squash,
    output logic [NUM-1:0] o_hit_slot,
    output logic o_debug_entry,
    output logic o_exc_take,
    output logic o_cause_we,
    output logic [31:0] o_cause,
    output logic o_fault_we,
    output logic [31:0] o_fault_addr
);
    // -----------------------------------------------------------------
    // csr decode
    // -----------------------------------------------------------------
    logic [SEL_W-1:0] sel_q;
    logic [NUM-1:0] owner;
    logic [31:0] ctrl_rd [NUM];
    logic [31:0] addr_rd [NUM];
    logic is_sel;
    logic is_first;
    logic is_second;
    logic is_third;
    logic is_data;
    logic mapped;
    logic illegal;
    logic wr_ok;
    logic [31:0] next_rdata;

    always_comb begin
        is_sel = 1'b0;
        is_first = 1'b0;
        is_second = 1'b0;
        is_third = 1'b0;
        if (i_csr_addr == breakpoint_pkg::CSR_TRIGGER_SELECT) begin
            is_sel = 1'b1;
        end else if (i_csr_addr
                == breakpoint_pkg::CSR_TRIGGER_DATA_FIRST) begin
            is_first = 1'b1;
        end else if (i_csr_addr
                == breakpoint_pkg::CSR_TRIGGER_DATA_SECOND) begin
            is_second = 1'b1;
        end else if (i_csr_addr
                == breakpoint_pkg::CSR_TRIGGER_DATA_THIRD) begin
            is_third = 1'b1;
        end
    end

    assign is_data = is_first | is_second | is_third;
    assign mapped = is_sel | is_data;
    // machine mode may not touch a slot held by the debugger
    assign illegal = i_csr_req & is_data & ~i_debug_mode & owner[sel_q]; // R19
    assign wr_ok = i_csr_req & i_csr_we & ~illegal;

    // -----------------------------------------------------------------
    // slot select
    // -----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sel_q <= '0;
        end else if (i_ce && wr_ok && is_sel) begin
            if (i_csr_wdata < 32'(NUM)) begin // R20
                sel_q <= i_csr_wdata[SEL_W-1:0];
            end
        end
    end

    // -----------------------------------------------------------------
    // trigger slots
    // -----------------------------------------------------------------
    logic [31:0] acc_hi;
    logic [NUM-1:0] raw_hit;
    logic [NUM-1:0] chain;
    logic [NUM-1:0] act_debug;
    logic [NUM-1:0] gate_prev;
    logic [NUM-1:0] fire;

    // -----------------------------------------------------------------
    // access span
    // -----------------------------------------------------------------
    // last byte of a wide or misaligned access, for any-byte matching
    access_span u_span (
        .i_addr(i_acc_addr),
        .i_size(i_acc_size),
        .o_hi(acc_hi)
    );

    // -----------------------------------------------------------------
    // per-slot state and compare
    // -----------------------------------------------------------------
    for (genvar g = 0; g < NUM; g++) begin : g_slot // R1
        logic [2:0] kind_en_q;
        logic [3:0] priv_en_q;
        logic [3:0] match_q;
        logic chain_q;
        logic debug_q;
        logic owner_q;
        logic [31:0] addr_q;
        logic wr_this;
        logic [3:0] w_match;
        logic [5:0] w_action;
        logic [3:0] type_rd;

        assign wr_this = wr_ok & (sel_q == SEL_W'(g)); // R2
        assign w_match = i_csr_wdata[breakpoint_pkg::MATCH_HI:
                                     breakpoint_pkg::MATCH_LO];
        assign w_action = i_csr_wdata[breakpoint_pkg::ACTION_HI:
                                      breakpoint_pkg::ACTION_LO];

        // -------------------------------------------------------------
        // control word
        // -------------------------------------------------------------
        // illegal values leave the field unchanged
        always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
                kind_en_q <= breakpoint_pkg::RST_KIND_EN;
                priv_en_q <= breakpoint_pkg::RST_PRIV_EN;
                match_q <= breakpoint_pkg::RST_MATCH;
                chain_q <= 1'b0; // R10
                debug_q <= 1'b0; // R4
                owner_q <= 1'b0; // R13
            end else if (i_ce && wr_this && is_first) begin
                kind_en_q <= i_csr_wdata[breakpoint_pkg::BIT_FETCH:
                                         breakpoint_pkg::BIT_LOAD]; // R5
                priv_en_q <= i_csr_wdata[breakpoint_pkg::BIT_PRIV_M:
                                         breakpoint_pkg::BIT_PRIV_U]; // R6
                if (w_match <= breakpoint_pkg::MATCH_LT) begin
                    match_q <= w_match; // R7
                end
                if (g < NUM - 1) begin
                    chain_q <= i_csr_wdata[breakpoint_pkg::BIT_CHAIN]; // R10
                end
                if (w_action == breakpoint_pkg::ACTION_EXCEPTION
                        || w_action == breakpoint_pkg::ACTION_DEBUG) begin
                    debug_q <= (w_action
                        == breakpoint_pkg::ACTION_DEBUG); // R4
                end
                if (i_debug_mode) begin
                    owner_q <= i_csr_wdata[breakpoint_pkg::BIT_OWNER]; // R13
                end
            end
        end

        // -------------------------------------------------------------
        // match address
        // -------------------------------------------------------------
        // all bits writable
        always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
                addr_q <= breakpoint_pkg::RST_ADDRESS;
            end else if (i_ce && wr_this && is_second) begin
                addr_q <= i_csr_wdata; // R14
            end
        end

        // -------------------------------------------------------------
        // read view
        // -------------------------------------------------------------
        assign type_rd = (owner_q && !i_debug_mode)
            ? breakpoint_pkg::TYPE_NONE
            : breakpoint_pkg::TYPE_ADDR_MATCH; // R3 R13
        // timing, select and the spare bit read zero
        assign ctrl_rd[g] = {type_rd, owner_q,
            breakpoint_pkg::MASKMAX_VALUE, 3'h0, // R9 R12
            {5'h00, debug_q}, chain_q, match_q, priv_en_q, kind_en_q};
        assign addr_rd[g] = addr_q;
        assign owner[g] = owner_q;
        assign chain[g] = chain_q;
        assign act_debug[g] = debug_q;

        // -------------------------------------------------------------
        // address compare
        // -------------------------------------------------------------
        slot_compare u_cmp (
            .i_match(match_q),
            .i_trig(addr_q),
            .i_kind_en(kind_en_q),
            .i_priv_en(priv_en_q),
            .i_lo(i_acc_addr),
            .i_hi(acc_hi),
            .i_load(i_acc_load),
            .i_store(i_acc_store),
            .i_fetch(i_acc_fetch),
            .i_priv(i_priv),
            .o_hit(raw_hit[g])
        );

        // -------------------------------------------------------------
        // chaining
        // -------------------------------------------------------------
        // a chained slot only lets its partner fire, never fires itself
        if (g == 0) begin : g_first
            assign gate_prev[g] = 1'b1;
        end else begin : g_next
            assign gate_prev[g] = ~chain[g-1] | raw_hit[g-1]; // R11
        end
        assign fire[g] = i_acc_valid & ~i_debug_mode & raw_hit[g]
            & gate_prev[g] & ~chain[g]; // R10 R11
    end

    // -----------------------------------------------------------------
    // csr read and response
    // -----------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h00000000;
        if (is_sel) begin
            next_rdata = 32'(sel_q);
        end else if (is_first) begin
            next_rdata = ctrl_rd[sel_q]; // R2
        end else if (is_second) begin
            next_rdata = addr_rd[sel_q]; // R2
        end else if (is_third) begin
            next_rdata = 32'h00000000; // R2
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_csr_ack <= 1'b0;
            o_csr_illegal <= 1'b0;
            o_csr_rdata <= 32'h00000000;
        end else if (i_ce) begin
            o_csr_ack <= i_csr_req & mapped;
            o_csr_illegal <= illegal; // R19
            o_csr_rdata <= illegal ? 32'h00000000 : next_rdata;
        end
    end

    // -----------------------------------------------------------------
    // trap selection: lowest firing slot decides the action
    // -----------------------------------------------------------------
    logic pick_debug;

    always_comb begin
        pick_debug = 1'b0;
        for (int k = NUM - 1; k >= 0; k--) begin
            if (fire[k]) begin
                pick_debug = act_debug[k];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_chk_valid <= 1'b0;
            o_bp_hit <= 1'b0;
            o_bp_squash <= 1'b0;
            o_hit_slot <= '0;
        end else if (i_ce) begin
            o_chk_valid <= i_acc_valid;
            o_bp_hit <= |fire;
            o_bp_squash <= |fire; // R15
            o_hit_slot <= fire;
        end
    end

    logic any_fire;
    logic exc_fire;

    assign any_fire = |fire;
    assign exc_fire = any_fire & ~pick_debug; // R18

    // -----------------------------------------------------------------
    // trap action pulses
    // -----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_debug_entry <= 1'b0;
            o_exc_take <= 1'b0;
            o_cause_we <= 1'b0;
            o_fault_we <= 1'b0;
        end else if (i_ce) begin
            o_debug_entry <= any_fire & pick_debug; // R17
            o_exc_take <= exc_fire; // R18
            o_cause_we <= exc_fire; // R17 R18
            o_fault_we <= exc_fire; // R17 R18
        end
    end

    // -----------------------------------------------------------------
    // trap cause and fault address, held until the next exception
    // -----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_cause <= 32'h00000000;
        end else if (i_ce && exc_fire) begin
            o_cause <= breakpoint_pkg::CAUSE_BREAKPOINT; // R18
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_fault_addr <= 32'h00000000;
        end else if (i_ce && exc_fire) begin
            o_fault_addr <= i_acc_addr; // R18
        end
    end
endmodule

// ==== pipe_model.sv ====
// core pipeline model presenting one access at a time
`timescale 1ns/1ps
module pipe_model (
    // clock
    input wire logic i_clk,
    // access
    output logic o_valid,
    output logic o_load,
    output logic o_store,
    output logic o_fetch,
    output logic [31:0] o_addr,
    output logic [1:0] o_size
);
    initial begin
        o_valid = 1'b0;
        {o_fetch, o_store, o_load} = 3'h0;
        o_addr = 32'h0;
        o_size = 2'h0;
    end
    task automatic present(input logic [2:0] k, input logic [31:0] a,
                           input logic [1:0] s);
        @(posedge i_clk);
        o_valid <= 1'b1;
        {o_fetch, o_store, o_load} <= k;
        o_addr <= a;
        o_size <= s;
        @(posedge i_clk);
        o_valid <= 1'b0;
        {o_fetch, o_store, o_load} <= 3'h0;
        // no stale address once released
        o_addr <= ~a;
        o_size <= ~s;
    endtask
endmodule

// ==== slot_compare.sv ====
// address, access-kind and privilege comparison for one trigger slot
`timescale 1ns/1ps
module slot_compare (
    // slot settings
    input wire logic [3:0] i_match,
    input wire logic [31:0] i_trig,
    input wire logic [2:0] i_kind_en,
    input wire logic [3:0] i_priv_en,
    // access
    input wire logic [31:0] i_lo,
    input wire logic [31:0] i_hi,
    input wire logic i_load,
    input wire logic i_store,
    input wire logic i_fetch,
    input wire logic [1:0] i_priv,
    // result
    output logic o_hit
);
    logic [31:0] mask;
    logic [31:0] base;
    logic [31:0] top;
    logic addr_hit;
    logic kind_hit;

    // unary range mask, capped at the largest supported size
    assign mask[0] = (i_match == breakpoint_pkg::MATCH_NAPOT); // R8
    for (genvar i = 1; i < 32; i++) begin : g_mask
        if (i < breakpoint_pkg::MASK_LOG2_MAX) begin : g_on
            assign mask[i] = mask[i-1] & i_trig[i-1]; // R8 R9
        end else begin : g_off
            assign mask[i] = 1'b0; // R9
        end
    end

    assign base = i_trig & ~mask;
    assign top = i_trig | mask;

    // any byte of the access inside the range counts
    always_comb begin
        case (i_match) // R7
            breakpoint_pkg::MATCH_EXACT,
            breakpoint_pkg::MATCH_NAPOT:
                addr_hit = (i_lo <= top) && (i_hi >= base); // R16
            breakpoint_pkg::MATCH_GE: addr_hit = (i_hi >= i_trig); // R11
            breakpoint_pkg::MATCH_LT: addr_hit = (i_lo < i_trig); // R11
            default: addr_hit = 1'b0;
        endcase
    end

    assign kind_hit = (i_kind_en[breakpoint_pkg::BIT_LOAD] & i_load)
        | (i_kind_en[breakpoint_pkg::BIT_STORE] & i_store)
        | (i_kind_en[breakpoint_pkg::BIT_FETCH] & i_fetch); // R5
    assign o_hit = addr_hit & kind_hit & i_priv_en[i_priv]; // R6
endmodule

// ==== testbench.sv ====
// self-checking testbench for the breakpoint trigger unit
`timescale 1ns/1ps
module testbench;
    // ----
    // signals
    // ----
    logic clk = 1'b0;
    logic rst_n, ce, dbg, req, we;
    logic [1:0] priv;
    logic [11:0] addr;
    logic [31:0] wdata, rdata, cause, faddr, aa;
    logic ack, ill, chkv, hit, sq, dent, exc, cwe, fwe;
    logic av, al, as, af;
    logic [1:0] slot, asz;
    int fail_count = 0;
    int compares = 0;
    always #2 clk = ~clk;
    pipe_model i_pipe (.i_clk(clk), .o_valid(av), .o_load(al),
        .o_store(as), .o_fetch(af), .o_addr(aa), .o_size(asz));
    hw_breakpoint_trigger_unit i_dut (.i_clk(clk), .i_rst_n(rst_n),
        .i_ce(ce), .i_debug_mode(dbg), .i_priv(priv), .i_csr_req(req),
        .i_csr_we(we), .i_csr_addr(addr), .i_csr_wdata(wdata),
        .o_csr_ack(ack), .o_csr_illegal(ill), .o_csr_rdata(rdata),
        .i_acc_valid(av), .i_acc_load(al), .i_acc_store(as),
        .i_acc_fetch(af), .i_acc_addr(aa), .i_acc_size(asz),
        .o_chk_valid(chkv), .o_bp_hit(hit), .o_bp_squash(sq),
        .o_hit_slot(slot), .o_debug_entry(dent), .o_exc_take(exc),
        .o_cause_we(cwe), .o_cause(cause), .o_fault_we(fwe),
        .o_fault_addr(faddr));
    // ----
    // tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] e);
        compares++;
        if (seen !== e) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, e);
        end
    endtask
    task automatic conclude();
        if (fail_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic csr(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        wdata <= ~d;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        csr(1'b0, a, 32'h0);
        check({30'h0, ack, ill}, 32'h2);
        check(rdata, e);
    endtask
    task automatic mode(input logic m);
        @(posedge clk);
        dbg <= m;
    endtask
    task automatic prog(input logic s, input logic [31:0] c,
                        input logic [31:0] a);
        mode(1'b1);
        csr(1'b1, 12'h7a0, {31'h0, s});
        csr(1'b1, 12'h7a1, c);
        csr(1'b1, 12'h7a2, a);
        mode(1'b0);
    endtask
    task automatic acc(input logic [2:0] k, input logic [31:0] a,
        input logic [1:0] s, input logic [1:0] es, input logic ed);
        i_pipe.present(k, a, s);
        // outputs launched at that edge settle just after it
        #1;
        check({27'h0, chkv, hit, sq, dent, exc},
              {27'h0, 1'b1, |es, |es, ed, |es & ~ed});
        check({30'h0, slot}, {30'h0, es});
        check({30'h0, cwe, fwe}, {30'h0, |es & ~ed, |es & ~ed});
        if (|es && !ed) begin
            check(faddr, a);
            check(cause, breakpoint_pkg::CAUSE_BREAKPOINT);
        end
    endtask
    // ----
    // tests
    // ----
    initial begin
        #40000;
        fail_count++;
        conclude();
    end
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        dbg = 1'b1;
        priv = 2'h3;
        req = 1'b0;
        we = 1'b0;
        addr = 12'h0;
        wdata = 32'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(12'h7a0, 32'h0);
        rd(12'h7a1, 32'h20800000);
        csr(1'b1, 12'h7a1, 32'hffffffff);
        rd(12'h7a1, 32'h2880087f);
        mode(1'b0);
        csr(1'b1, 12'h7a2, 32'h1234);
        check({30'h0, ack, ill}, 32'h3);
        csr(1'b0, 12'h7a1, 32'h0);
        check(rdata, 32'h0);
        csr(1'b1, 12'h7a0, 32'h2);
        rd(12'h7a0, 32'h0);
        csr(1'b1, 12'h7a0, 32'h1);
        rd(12'h7a0, 32'h1);
        rd(12'h7a1, 32'h20800000);
        csr(1'b0, 12'h7a4, 32'h0);
        check({31'h0, ack}, 32'h0);
        csr(1'b0, 12'h7a3, 32'h0);
        check({31'h0, ack}, 32'h1);
        mode(1'b1);
        csr(1'b1, 12'h7a0, 32'h0);
        rd(12'h7a2, 32'h0);
        csr(1'b1, 12'h7a2, 32'ha5a55a5a);
        rd(12'h7a2, 32'ha5a55a5a);
        // clock enable low: the write must be frozen out
        @(posedge clk) ce <= 1'b0;
        csr(1'b1, 12'h7a2, 32'h0);
        check({31'h0, ack}, 32'h0);
        @(posedge clk) ce <= 1'b1;
        rd(12'h7a2, 32'ha5a55a5a);
        for (int k = 0; k < 8; k++) begin
            prog(1'b0, 32'h40 | k, 32'h100);
            acc(3'(1 << (k % 3)), 32'h100, 2'h0, {1'b0, k[k % 3]}, 1'b0);
        end
        for (int p = 0; p < 4; p++) begin
            prog(1'b0, 32'h4 | (32'h8 << p), 32'h100);
            for (int q = 0; q < 4; q++) begin
                @(posedge clk) priv <= q[1:0];
                acc(3'h4, 32'h100, 2'h0, {1'b0, p == q}, 1'b0);
            end
        end
        @(posedge clk) priv <= 2'h3;
        prog(1'b0, 32'h44, 32'h100);
        acc(3'h4, 32'h100, 2'h0, 2'h1, 1'b0);
        acc(3'h4, 32'h101, 2'h0, 2'h0, 1'b0);
        acc(3'h4, 32'hfe, 2'h2, 2'h1, 1'b0);
        prog(1'b0, 32'hc4, 32'h203);
        acc(3'h4, 32'h207, 2'h0, 2'h1, 1'b0);
        acc(3'h4, 32'h208, 2'h0, 2'h0, 1'b0);
        prog(1'b0, 32'h10c4, 32'h203);
        acc(3'h4, 32'h204, 2'h0, 2'h1, 1'b1);
        mode(1'b1);
        acc(3'h4, 32'h204, 2'h0, 2'h0, 1'b0);
        prog(1'b0, 32'h944, 32'h300);
        prog(1'b1, 32'h1c4, 32'h310);
        acc(3'h4, 32'h308, 2'h0, 2'h2, 1'b0);
        acc(3'h4, 32'h310, 2'h0, 2'h0, 1'b0);
        acc(3'h4, 32'h2ff, 2'h0, 2'h0, 1'b0);
        conclude();
    end
endmodule
